// ===== sim/pes_lp_model.sv
// pes_lp_model: far side of the status bank, the pcs and negotiation logic
// facing the link partner, driving its status pins as asynchronous levels
// assumes: the bench commands the wanted pin levels, indexed by the pes_pkg pin positions
`timescale 1ns/1ps
`default_nettype none

module pes_lp_model (
  input wire logic [pes_pkg::PES_IN_W-1:0] want, // commanded pin levels
  output logic [pes_pkg::PES_IN_W-1:0] pins // pin levels seen by the bank
);
  import pes_pkg::*;

  // -------------------------------------------------------------
  // pin drive
  // -------------------------------------------------------------
  // pins move off the clock grid so the synchroniser is really exercised;
  // one process owns the pins so they have a single driver
  initial begin
    pins = '0;
    forever begin
      @(want);
      pins <= #3.7 want;
    end
  end
endmodule : pes_lp_model
`default_nettype wire

// ===== sim/tb.sv
// tb: self-checking bench for the port eee status register bank
// assumes: pes_regs as top, apb master in this file, pins driven through pes_lp_model
`timescale 1ns/1ps
`default_nettype none

module tb;
  import pes_pkg::*;

  logic pclk, presetn, psel, penable, pwrite, pcs_np_enable, serr, adv_b;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, exp;
  logic pready, pslverr, eee_adv_100tx, eee_active;
  logic [PES_IN_W-1:0] want, pins;
  logic [31:0] rs;
  int err_count, n_checks;

  pes_lp_model lpm (.want(want), .pins(pins));
  pes_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pcs_np_enable(pcs_np_enable), .tx_lpi(pins[PES_IN_TX_LPI]), .rx_lpi(pins[PES_IN_RX_LPI]),
    .wake_timer_done(pins[PES_IN_WAKE]), .pd_fault(pins[PES_IN_PD_FAULT]),
    .page_received(pins[PES_IN_PAGE]), .lp_next_page_able(pins[PES_IN_LP_NP]),
    .lp_an_able(pins[PES_IN_LP_AN]), .lp_eee_100tx(pins[PES_IN_LP_EEE]),
    .hw_eee_np(pins[PES_IN_HW_EEE]), .fiber_mode(pins[PES_IN_FIBER]),
    .eee_adv_100tx(eee_adv_100tx), .eee_active(eee_active));

  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  function automatic logic [31:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction : xs

  // expected status word; fiber hides every eee indication
  function automatic logic [31:0] exp_cs(input logic [15:0] lat);
    logic g;
    g = ~want[PES_IN_FIBER];
    exp_cs = {16'h0000, 16'h8064 | lat};
    exp_cs[14] = want[PES_IN_HW_EEE] & g & pcs_np_enable & adv_b;
    exp_cs[12] = want[PES_IN_TX_LPI] & g;
    exp_cs[10] = want[PES_IN_RX_LPI] & g;
    exp_cs[3] = want[PES_IN_LP_NP];
    exp_cs[0] = want[PES_IN_LP_AN];
  endfunction : exp_cs

  task automatic w(input int n);
    repeat (n) @(posedge pclk);
  endtask : w

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    n_checks++;
    if (seen !== ex) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, ex, seen);
    end
  endtask : chk

  // one apb transfer, entered just after a rising edge, ends one idle cycle later
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [15:0] wd);
    int n;
    n = 0;
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= {16'h0000, wd};
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (n >= 20) err_count++;
    rd = prdata;
    serr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask : apb

  task automatic pulse(input int pin);
    want[pin] <= 1'h1;
    w(6);
    want[pin] <= 1'h0;
    w(6);
  endtask : pulse

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out

  // -------------------------------------------------------------
  // clock and watchdog
  // -------------------------------------------------------------
  initial begin
    pclk = 1'h0;
    forever #5 pclk = ~pclk;
  end

  initial begin
    w(20000);
    err_count++;
    close_out();
  end

  // -------------------------------------------------------------
  // tests
  // -------------------------------------------------------------
  initial begin
    int n, pin, lb;
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    pcs_np_enable = 1'h1;
    want = '0;
    adv_b = 1'h1;
    rs = 32'h00000024;
    err_count = 0;
    n_checks = 0;
    w(16);
    presetn <= 1'h1;
    w(2);
    apb(1'h0, PES_IDX_ADV, 16'h0000);
    chk("adv reset", rd, 32'h00000002);
    apb(1'h0, PES_IDX_CS, 16'h0000);
    chk("cs reset", rd, 32'h00008064);
    apb(1'h0, 8'hE6, 16'h0000);
    chk("unmapped", {serr, rd[30:0]}, 32'h80000000);
    $display("test reset done");
    // random partner state, advertisement and pcs enable
    for (int i = 0; i < 10; i++) begin
      exp = xs();
      adv_b = exp[6];
      apb(1'h1, PES_IDX_ADV, {14'h0000, exp[6], 1'h0});
      want[PES_IN_LP_NP] <= exp[0];
      want[PES_IN_LP_AN] <= exp[1];
      want[PES_IN_HW_EEE] <= (i < 2) ? 1'h1 : exp[2];
      want[PES_IN_LP_EEE] <= exp[3];
      want[PES_IN_FIBER] <= (i < 2) ? 1'h0 : exp[5];
      pcs_np_enable <= (i == 1) ? 1'h0 : exp[4] | (i == 0);
      w(6);
      apb(1'h0, PES_IDX_CS, 16'h0000);
      chk("cs live", rd, exp_cs(16'h0000));
      apb(1'h0, PES_IDX_ADV, 16'h0000);
      chk("adv", rd, {22'h0, want[PES_IN_LP_EEE] & ~want[PES_IN_FIBER], 7'h0, adv_b, 1'h0});
      chk("adv out", eee_adv_100tx, adv_b & pcs_np_enable & ~want[PES_IN_FIBER]);
      chk("active", eee_active, (exp_cs(16'h0000) >> 14) & 32'h00000001);
    end
    want <= '0;
    pcs_np_enable <= 1'h1;
    w(6);
    $display("test random status done");
    // wake error counter: fiber blocks counting, writes ignored, read clears
    want[PES_IN_FIBER] <= 1'h1;
    pulse(PES_IN_WAKE);
    want[PES_IN_FIBER] <= 1'h0;
    w(6);
    apb(1'h0, PES_IDX_WEC, 16'h0000);
    chk("wec fiber", rd, 32'h00000000);
    n = xs() % 5 + 1;
    repeat (n) pulse(PES_IN_WAKE);
    apb(1'h1, PES_IDX_WEC, 16'hFFFF);
    apb(1'h0, PES_IDX_WEC, 16'h0000);
    chk("wec count", rd, n);
    apb(1'h0, PES_IDX_WEC, 16'h0000);
    chk("wec clear", rd, 32'h00000000);
    $display("test wake count done");
    // lpi latches clear only by writing one
    for (int k = 0; k < 2; k++) begin
      pin = k ? PES_IN_RX_LPI : PES_IN_TX_LPI;
      lb = k ? 11 : 13;
      want[pin] <= 1'h1;
      w(6);
      apb(1'h0, PES_IDX_CS, 16'h0000);
      chk("lpi live", rd, exp_cs(16'h1 << lb));
      want[pin] <= 1'h0;
      w(6);
      apb(1'h0, PES_IDX_CS, 16'h0000);
      apb(1'h0, PES_IDX_CS, 16'h0000);
      chk("lpi held", rd, exp_cs(16'h1 << lb));
      apb(1'h1, PES_IDX_CS, 16'h8000 | (16'h1 << lb));
      apb(1'h0, PES_IDX_CS, 16'h0000);
      chk("lpi cleared", rd, exp_cs(16'h0000));
    end
    // fault and page latches clear on read
    for (int k = 0; k < 2; k++) begin
      pin = k ? PES_IN_PAGE : PES_IN_PD_FAULT;
      pulse(pin);
      apb(1'h0, PES_IDX_CS, 16'h0000);
      chk("rc latch", rd, exp_cs(k ? 16'h0002 : 16'h0010));
      apb(1'h0, PES_IDX_CS, 16'h0000);
      chk("rc cleared", rd, exp_cs(16'h0000));
    end
    $display("test latches done");
    close_out();
  end
endmodule : tb
`default_nettype wire

// ===== verilog/pes_pkg.sv
// pes_pkg: register map, field positions and reset values of the port eee status bank
// assumes: apb with 32-bit data, 12-bit byte address, one register per aligned word

package pes_pkg;

  // ---------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam int PES_ADDR_W = 12;
  localparam logic [7:0] PES_IDX_ADV = 8'hE0; // port_eee_advertisement
  localparam logic [7:0] PES_IDX_WEC = 8'hE2; // port_eee_wake_error_count
  localparam logic [7:0] PES_IDX_CS = 8'hE4; // port_eee_ctrl_status_an_expansion

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int PES_ADV_LP_100TX = 9;
  localparam int PES_ADV_100TX = 1;
  localparam int PES_CS_RSVD15 = 15;
  localparam int PES_CS_HW_EEE = 14;
  localparam int PES_CS_TX_LAT = 13;
  localparam int PES_CS_TX_LIVE = 12;
  localparam int PES_CS_RX_LAT = 11;
  localparam int PES_CS_RX_LIVE = 10;
  localparam int PES_CS_RSVD_LO = 8;
  localparam int PES_CS_NP_LOC_ABLE = 6;
  localparam int PES_CS_NP_LOC_ALT = 5;
  localparam int PES_CS_PD_FAULT = 4;
  localparam int PES_CS_LP_NP_ABLE = 3;
  localparam int PES_CS_NP_ABLE = 2;
  localparam int PES_CS_PAGE_RX = 1;
  localparam int PES_CS_LP_AN_ABLE = 0;

  // ---------------------------------------------------------------
  // reset and fixed values
  // ---------------------------------------------------------------
  localparam logic PES_ADV_100TX_RST = 1'h1;
  localparam logic PES_RSVD15_RST = 1'h1;
  localparam logic [1:0] PES_RSVD98_RST = 2'h0;
  localparam logic [15:0] PES_WEC_RST = 16'h0000;
  localparam logic [15:0] PES_WEC_MAX = 16'hFFFF;
  localparam logic PES_NP_LOC_ABLE_VAL = 1'h1;
  localparam logic PES_NP_LOC_ALT_VAL = 1'h1;
  localparam logic PES_NP_ABLE_VAL = 1'h1;

  // ---------------------------------------------------------------
  // positions of the pin inputs inside the synchroniser vector
  // ---------------------------------------------------------------
  localparam int PES_IN_TX_LPI = 0;
  localparam int PES_IN_RX_LPI = 1;
  localparam int PES_IN_WAKE = 2;
  localparam int PES_IN_PD_FAULT = 3;
  localparam int PES_IN_PAGE = 4;
  localparam int PES_IN_LP_NP = 5;
  localparam int PES_IN_LP_AN = 6;
  localparam int PES_IN_LP_EEE = 7;
  localparam int PES_IN_HW_EEE = 8;
  localparam int PES_IN_FIBER = 9;
  localparam int PES_IN_W = 10;

  // byte address of a register from its index
  function automatic logic [PES_ADDR_W-1:0] pes_reg_addr(input logic [7:0] idx);
    return {2'h0, idx, 2'h0};
  endfunction : pes_reg_addr

endpackage : pes_pkg

// ===== verilog/pes_regs.sv
// pes_regs: apb register bank for one port's eee and auto-negotiation expansion status
// assumes: pcs and negotiation pins are asynchronous levels; pcs_np_enable comes from
// logic on pclk; apb master follows apb3 timing
`timescale 1ns/1ps
`default_nettype none

module pes_regs (
  input wire logic pclk, // system clock, 100 MHz
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction, high for write
  input wire logic [pes_pkg::PES_ADDR_W-1:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic pcs_np_enable, // next-page enable from pcs eee control
  input wire logic tx_lpi, // transmit pcs receiving lpi (pin)
  input wire logic rx_lpi, // receive pcs receiving lpi (pin)
  input wire logic wake_timer_done, // wake took too long (pin)
  input wire logic pd_fault, // parallel detection fault (pin)
  input wire logic page_received, // new negotiation page (pin)
  input wire logic lp_next_page_able, // partner next-page capable (pin)
  input wire logic lp_an_able, // partner negotiation capable (pin)
  input wire logic lp_eee_100tx, // partner eee for 100BASE-TX (pin)
  input wire logic hw_eee_np, // eee agreed by next-page exchange (pin)
  input wire logic fiber_mode, // port on fiber media (pin)
  output logic eee_adv_100tx, // advertise eee for 100BASE-TX
  output logic eee_active // eee in force on this port
);
  import pes_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic adv_100tx;
    logic rsvd15;
    logic [1:0] rsvd98;
    logic tx_lat;
    logic rx_lat;
    logic pdf_lat;
    logic page_lat;
    logic eee_act;
    logic eee_adv;
  } pes_regs_t;

  localparam pes_regs_t PES_REGS_RST = '{
    pready: 1'h0,
    pslverr: 1'h0,
    prdata: 32'h0000_0000,
    adv_100tx: PES_ADV_100TX_RST,
    rsvd15: PES_RSVD15_RST,
    rsvd98: PES_RSVD98_RST,
    tx_lat: 1'h0,
    rx_lat: 1'h0,
    pdf_lat: 1'h0,
    page_lat: 1'h0,
    eee_act: 1'h0,
    eee_adv: PES_ADV_100TX_RST
  };

  pes_regs_t q, d;

  // ---------------------------------------------------------------
  // pin synchronisers and wake counter
  // ---------------------------------------------------------------
  logic [PES_IN_W-1:0] pins_raw;
  logic [PES_IN_W-1:0] pins;
  logic [15:0] wec_count;
  logic wec_rd_clr;
  logic fiber;
  logic tx_live;
  logic rx_live;
  logic lp_eee_live;
  logic hw_eee_live;

  always_comb begin
    pins_raw = '0;
    pins_raw[PES_IN_TX_LPI] = tx_lpi;
    pins_raw[PES_IN_RX_LPI] = rx_lpi;
    pins_raw[PES_IN_WAKE] = wake_timer_done;
    pins_raw[PES_IN_PD_FAULT] = pd_fault;
    pins_raw[PES_IN_PAGE] = page_received;
    pins_raw[PES_IN_LP_NP] = lp_next_page_able;
    pins_raw[PES_IN_LP_AN] = lp_an_able;
    pins_raw[PES_IN_LP_EEE] = lp_eee_100tx;
    pins_raw[PES_IN_HW_EEE] = hw_eee_np;
    pins_raw[PES_IN_FIBER] = fiber_mode;
  end

  pes_sync3 #(
    .W(PES_IN_W)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din(pins_raw),
    .dout(pins)
  );

  // eee indications are forced quiet on fiber media
  assign fiber = pins[PES_IN_FIBER];
  assign tx_live = pins[PES_IN_TX_LPI] & ~fiber;
  assign rx_live = pins[PES_IN_RX_LPI] & ~fiber;
  assign lp_eee_live = pins[PES_IN_LP_EEE] & ~fiber;
  assign hw_eee_live = pins[PES_IN_HW_EEE] & ~fiber;

  pes_wake_cnt u_wec (
    .pclk(pclk),
    .presetn(presetn),
    .wake_done(pins[PES_IN_WAKE]),
    .enable(~fiber),
    .rd_clr(wec_rd_clr),
    .rd_cap(q.prdata[15:0]),
    .count(wec_count)
  );

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  logic setup;
  logic acc;
  logic hit_adv;
  logic hit_wec;
  logic hit_cs;
  logic [15:0] adv_word;
  logic [15:0] cs_word;

  assign setup = psel & ~penable;
  assign acc = psel & penable & q.pready;
  assign hit_adv = paddr == pes_reg_addr(PES_IDX_ADV);
  assign hit_wec = paddr == pes_reg_addr(PES_IDX_WEC);
  assign hit_cs = paddr == pes_reg_addr(PES_IDX_CS);
  assign wec_rd_clr = acc & ~pwrite & hit_wec;

  // read images; reserved read-only bits read zero
  always_comb begin
    adv_word = 16'h0000;
    adv_word[PES_ADV_LP_100TX] = lp_eee_live;
    adv_word[PES_ADV_100TX] = q.adv_100tx;
    cs_word = 16'h0000;
    cs_word[PES_CS_RSVD15] = q.rsvd15;
    cs_word[PES_CS_HW_EEE] = q.eee_act;
    cs_word[PES_CS_TX_LAT] = q.tx_lat;
    cs_word[PES_CS_TX_LIVE] = tx_live;
    cs_word[PES_CS_RX_LAT] = q.rx_lat;
    cs_word[PES_CS_RX_LIVE] = rx_live;
    cs_word[PES_CS_RSVD_LO +: 2] = q.rsvd98;
    cs_word[PES_CS_NP_LOC_ABLE] = PES_NP_LOC_ABLE_VAL;
    cs_word[PES_CS_NP_LOC_ALT] = PES_NP_LOC_ALT_VAL;
    cs_word[PES_CS_PD_FAULT] = q.pdf_lat;
    cs_word[PES_CS_LP_NP_ABLE] = pins[PES_IN_LP_NP];
    cs_word[PES_CS_NP_ABLE] = PES_NP_ABLE_VAL;
    cs_word[PES_CS_PAGE_RX] = q.page_lat;
    cs_word[PES_CS_LP_AN_ABLE] = pins[PES_IN_LP_AN];
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  // read data is captured in the setup cycle so pready and prdata leave flip-flops;
  // read-to-clear bits drop only if the captured copy showed them, so an event landing
  // between capture and the access edge is not lost
  always_comb begin
    d = q;
    d.pready = 1'h0;
    d.pslverr = 1'h0;
    if (setup) begin
      d.pready = 1'h1;
      d.prdata = 32'h0000_0000;
      if (hit_adv) begin
        d.prdata[15:0] = adv_word;
      end else if (hit_wec) begin
        d.prdata[15:0] = wec_count;
      end else if (hit_cs) begin
        d.prdata[15:0] = cs_word;
      end else begin
        d.pslverr = 1'h1;
      end
    end
    // software writes and clears, taken at the access edge
    if (acc && pwrite && hit_adv) begin
      d.adv_100tx = pwdata[PES_ADV_100TX];
    end
    if (acc && pwrite && hit_cs) begin
      d.rsvd15 = pwdata[PES_CS_RSVD15];
      d.rsvd98 = pwdata[PES_CS_RSVD_LO +: 2];
      d.tx_lat = q.tx_lat & ~pwdata[PES_CS_TX_LAT];
      d.rx_lat = q.rx_lat & ~pwdata[PES_CS_RX_LAT];
    end
    if (acc && !pwrite && hit_cs) begin
      d.pdf_lat = q.pdf_lat & ~q.prdata[PES_CS_PD_FAULT];
      d.page_lat = q.page_lat & ~q.prdata[PES_CS_PAGE_RX];
    end
    // hardware sets win over any clear in the same cycle
    d.tx_lat = d.tx_lat | tx_live;
    d.rx_lat = d.rx_lat | rx_live;
    d.pdf_lat = d.pdf_lat | pins[PES_IN_PD_FAULT];
    d.page_lat = d.page_lat | pins[PES_IN_PAGE];
    // eee only in force when advertised, agreed and next pages are enabled
    d.eee_act = hw_eee_live & pcs_np_enable & q.adv_100tx;
    d.eee_adv = q.adv_100tx & pcs_np_enable & ~fiber;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= PES_REGS_RST;
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign eee_adv_100tx = q.eee_adv;
  assign eee_active = q.eee_act;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  chk_adv_write_bit: assert property (@(posedge pclk) disable iff (!presetn)
    (acc && pwrite && hit_adv) |=> q.adv_100tx == $past(pwdata[PES_ADV_100TX]))
    else $error("advertisement bit not written");
  chk_eee_off_np: assert property (@(posedge pclk) disable iff (!presetn)
    !pcs_np_enable |=> (!eee_active && !eee_adv_100tx))
    else $error("eee stayed on with next pages disabled");
  chk_fiber_no_eee: assert property (@(posedge pclk) disable iff (!presetn)
    fiber |=> (!eee_active && !$rose(q.tx_lat) && !$rose(q.rx_lat)))
    else $error("eee activity seen in fiber mode");
  chk_hw_status_read: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && hit_cs) |=> prdata[PES_CS_HW_EEE] == $past(q.eee_act))
    else $error("hardware eee status misreported");
  chk_tx_lat_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (q.tx_lat && !(acc && pwrite && hit_cs && pwdata[PES_CS_TX_LAT])) |=> q.tx_lat)
    else $error("transmit lpi latch dropped without write");
  chk_tx_live_read: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && hit_cs) |=> prdata[PES_CS_TX_LIVE] == $past(tx_live))
    else $error("transmit lpi live bit wrong");
  chk_rx_lat_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (q.rx_lat && !(acc && pwrite && hit_cs && pwdata[PES_CS_RX_LAT])) |=> q.rx_lat)
    else $error("receive lpi latch dropped without write");
  chk_rx_live_read: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && hit_cs) |=> prdata[PES_CS_RX_LIVE] == $past(rx_live))
    else $error("receive lpi live bit wrong");
  chk_np_location: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && hit_cs) |=> prdata[PES_CS_NP_LOC_ABLE -: 2] == 2'h3)
    else $error("next page location bits wrong");
  chk_pd_fault_set: assert property (@(posedge pclk) disable iff (!presetn)
    pins[PES_IN_PD_FAULT] |=> q.pdf_lat)
    else $error("parallel detection fault not latched");
  chk_lp_np_read: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && hit_cs) |=> prdata[PES_CS_LP_NP_ABLE] == $past(pins[PES_IN_LP_NP]))
    else $error("partner next page bit wrong");
  chk_local_np_read: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && hit_cs) |=> prdata[PES_CS_NP_ABLE])
    else $error("local next page bit not one");
  chk_page_set: assert property (@(posedge pclk) disable iff (!presetn)
    pins[PES_IN_PAGE] |=> q.page_lat)
    else $error("page received not latched");
  chk_lp_an_read: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && hit_cs) |=> prdata[PES_CS_LP_AN_ABLE] == $past(pins[PES_IN_LP_AN]))
    else $error("partner negotiation bit wrong");
  chk_lp_eee_read: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && hit_adv) |=> prdata[PES_ADV_LP_100TX] == $past(lp_eee_live))
    else $error("partner eee bit wrong");
  chk_page_rd_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (acc && !pwrite && hit_cs && prdata[PES_CS_PAGE_RX] && !pins[PES_IN_PAGE]) |=> !q.page_lat)
    else $error("page received not cleared by read");
  chk_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && !hit_adv && !hit_wec && !hit_cs) |=> (pready && pslverr && prdata == 32'h0000_0000))
    else $error("unmapped address not refused");

endmodule : pes_regs
`default_nettype wire

// ===== verilog/pes_sync3.sv
// pes_sync3: three-stage synchroniser with agreement filter for pin inputs
// assumes: inputs are asynchronous levels; output moves once stages two and three agree
`timescale 1ns/1ps
`default_nettype none

module pes_sync3 #(
  parameter int W = 1
) (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic [W-1:0] din, // raw pin levels
  output logic [W-1:0] dout // filtered levels
);
  import pes_pkg::*;

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] filt;
  } pes_sync_t;

  pes_sync_t q, d;

  // the first stage feeds only the second; filter looks at stages two and three
  always_comb begin
    d = q;
    d.s1 = din;
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.filt = (q.s2 & q.s3) | (q.filt & (q.s2 | q.s3));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign dout = q.filt;

endmodule : pes_sync3
`default_nettype wire

// ===== verilog/pes_wake_cnt.sv
// pes_wake_cnt: saturating 16-bit wake error counter, cleared by reading
// assumes: wake_done is already synchronised; rd_clr pulses once per completed read
`timescale 1ns/1ps
`default_nettype none

module pes_wake_cnt (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic wake_done, // wake timer expired level
  input wire logic enable, // low in fiber mode
  input wire logic rd_clr, // completed read of the counter
  input wire logic [15:0] rd_cap, // value returned by that read
  output logic [15:0] count // current count
);
  import pes_pkg::*;

  typedef struct packed {
    logic done_prev;
    logic [15:0] cnt;
  } pes_wec_t;

  pes_wec_t q, d;
  logic rise;
  logic [15:0] base;

  // subtract only what software saw, so counts made after data capture survive
  always_comb begin
    d = q;
    rise = wake_done & ~q.done_prev & enable;
    base = rd_clr ? q.cnt - rd_cap : q.cnt;
    d.done_prev = wake_done;
    d.cnt = (rise && base != PES_WEC_MAX) ? base + 16'h0001 : base;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '{done_prev: 1'h0, cnt: PES_WEC_RST};
    end else begin
      q <= d;
    end
  end

  assign count = q.cnt;

  chk_wec_rise_count: assert property (@(posedge pclk) disable iff (!presetn)
    (wake_done && !q.done_prev && enable && !rd_clr && q.cnt != PES_WEC_MAX) |=> q.cnt == $past(q.cnt) + 16'h0001)
    else $error("wake error count missed a rising edge");
  chk_wec_saturate: assert property (@(posedge pclk) disable iff (!presetn)
    (q.cnt == PES_WEC_MAX && !rd_clr) |=> q.cnt == PES_WEC_MAX)
    else $error("wake error count wrapped");
  chk_wec_fiber_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (!enable && !rd_clr) |=> q.cnt == $past(q.cnt))
    else $error("wake error count moved while disabled");

endmodule : pes_wake_cnt
`default_nettype wire
